// ===== design/adtp_pkg.sv
// package of constants for the second-channel trim and sample clock phase registers
// assumes a 16-bit write word at a 4-bit register address, one clock domain
package adtp_pkg;

	// =====================================================================
	// bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// =====================================================================
	// register addresses
	localparam logic [3:0] ADDR_Q_OFFSET_TRIM = 4'ha;
	localparam logic [3:0] ADDR_Q_FULL_SCALE_TRIM = 4'hb;
	localparam logic [3:0] ADDR_SAMPLE_CLOCK_FINE_DELAY = 4'he;
	localparam logic [3:0] ADDR_SAMPLE_CLOCK_COARSE_DELAY = 4'hf;

	// =====================================================================
	// power-on values of the whole words
	localparam logic [15:0] RST_Q_OFFSET_TRIM = 16'h007f;
	localparam logic [15:0] RST_Q_FULL_SCALE_TRIM = 16'h807f;
	localparam logic [15:0] RST_SAMPLE_CLOCK_FINE_DELAY = 16'h00ff;
	localparam logic [15:0] RST_SAMPLE_CLOCK_COARSE_DELAY = 16'h007f;

	// bits that software must write as ones in each word
	localparam logic [15:0] ONES_Q_OFFSET_TRIM = 16'h007f;
	localparam logic [15:0] ONES_Q_FULL_SCALE_TRIM = 16'h007f;
	localparam logic [15:0] ONES_SAMPLE_CLOCK_FINE_DELAY = 16'h00ff;
	localparam logic [15:0] ONES_SAMPLE_CLOCK_COARSE_DELAY = 16'h007f;

	// =====================================================================
	// field positions
	localparam int OFS_MAG_MSB = 15;
	localparam int OFS_MAG_LSB = 8;
	localparam int OFS_SIGN_BIT = 7;
	localparam int GAIN_MSB = 15;
	localparam int GAIN_LSB = 7;
	localparam int FINE_MSB = 15;
	localparam int FINE_LSB = 8;
	localparam int POL_BIT = 15;
	localparam int COARSE_MSB = 14;
	localparam int COARSE_LSB = 10;
	localparam int INTER_MSB = 9;
	localparam int INTER_LSB = 7;

	// =====================================================================
	// delay step sizes in picoseconds, and the width of the combined sum
	localparam int DELAY_SUM_W = 12;
	localparam logic [11:0] COARSE_STEP_PS = 12'h041;
	localparam logic [11:0] INTER_STEP_PS = 12'h00b;

endpackage

// ===== design/adtp_wr_if.sv
// write carrier between the trim register top and its word registers
// assumes the top drives it from its plain write port on the same clock
`timescale 1ns/1ps
interface adtp_wr_if;
	import adtp_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic strobe;
	modport src (output addr, output data, output strobe);
	modport dst (input addr, input data, input strobe);
endinterface

// ===== design/adtp_reg16.sv
// one write-only 16-bit configuration word that answers a single address
// assumes a synchronised active-low reset and a same-clock write carrier
`timescale 1ns/1ps
module adtp_reg16 import adtp_pkg::*; #(
	parameter logic [3:0] REG_ADDR = 4'h0,
	parameter logic [15:0] RST_VALUE = 16'h0000
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	adtp_wr_if.dst wr_bus,
	output logic [15:0] word_out
);

	// =====================================================================
	// word storage
	logic [15:0] word_reg;
	logic [15:0] word_next;

	// the whole word is taken as written; fixed bits are flagged, not forced
	always_comb begin
		word_next = word_reg;
		if (wr_bus.strobe && (wr_bus.addr == REG_ADDR)) begin
			word_next = wr_bus.data;
		end
	end

	// power-on value is a constant
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			word_reg <= RST_VALUE;
		end else begin
			word_reg <= word_next;
		end
	end

	assign word_out = word_reg;

endmodule // adtp_reg16

// ===== design/adtp_trim_regs.sv
// second-channel offset and gain trim plus sample clock phase registers
// assumes a same-clock master on the write port; analog trims sit outside
//
// Contract
// - bits 15:8 of the offset word hold an unsigned offset magnitude, 00h none to FFh about 45 mV.
// - bit 7 of the offset word picks the direction, zero positive and one negative.
// - each offset magnitude step stands for about 0.176 mV of input offset.
// - after power-on the offset magnitude and direction are both zero.
// - bits 15:7 of the full-scale word hold a 9-bit linear gain code, low bits written as ones.
// - the gain code spans 20 percent either side of 700 mV, with 100000000b as nominal.
// - after power-on the gain code is 100000000b, meaning no adjustment.
// - a new gain code takes effect without starting or asking for a calibration.
// - bits 15:8 of the fine phase word give a delay code of about 0.2 ps per step.
// - after power-on the fine delay code is zero.
// - bit 15 of the coarse phase word inverts the sample clock and resets to zero.
// - bits 14:10 give a coarse delay of about 65 ps per step, zero at reset.
// - bits 9:7 give an intermediate delay of about 11 ps per step, zero at reset.
// - coarse and intermediate delays add, up to about 2.1 ns in total.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module adtp_trim_regs import adtp_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] wr_addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	output logic [15:0] rd_data_out,
	output logic [7:0] q_offset_mag_out,
	output logic q_offset_neg_out,
	output logic [8:0] q_gain_code_out,
	output logic [7:0] fine_delay_out,
	output logic clock_invert_select_out,
	output logic [4:0] coarse_delay_out,
	output logic [2:0] intermediate_delay_out,
	output logic [11:0] combined_delay_ps_out,
	output logic fixed_bits_error_out
);

	// =====================================================================
	// reset release
	logic [1:0] rst_sync_reg;
	logic [1:0] rst_sync_next;
	logic rst_n;

	// assertion is immediate, release waits two edges to avoid metastability
	always_comb begin
		rst_sync_next = {rst_sync_reg[0], 1'b1};
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= rst_sync_next;
		end
	end

	assign rst_n = rst_sync_reg[1];

	// =====================================================================
	// write carrier and word registers
	adtp_wr_if wr_bus ();

	assign wr_bus.addr = wr_addr_in;
	assign wr_bus.data = wr_data_in;
	assign wr_bus.strobe = wr_strobe_in;

	logic [15:0] offset_word;
	logic [15:0] gain_word;
	logic [15:0] fine_word;
	logic [15:0] coarse_word;

	adtp_reg16 #(
		.REG_ADDR(ADDR_Q_OFFSET_TRIM),
		.RST_VALUE(RST_Q_OFFSET_TRIM)
	) u_offset (
		.clk_in(clk_in),
		.rst_b_in(rst_n),
		.wr_bus(wr_bus),
		.word_out(offset_word)
	);

	adtp_reg16 #(
		.REG_ADDR(ADDR_Q_FULL_SCALE_TRIM),
		.RST_VALUE(RST_Q_FULL_SCALE_TRIM)
	) u_gain (
		.clk_in(clk_in),
		.rst_b_in(rst_n),
		.wr_bus(wr_bus),
		.word_out(gain_word)
	);

	adtp_reg16 #(
		.REG_ADDR(ADDR_SAMPLE_CLOCK_FINE_DELAY),
		.RST_VALUE(RST_SAMPLE_CLOCK_FINE_DELAY)
	) u_fine (
		.clk_in(clk_in),
		.rst_b_in(rst_n),
		.wr_bus(wr_bus),
		.word_out(fine_word)
	);

	adtp_reg16 #(
		.REG_ADDR(ADDR_SAMPLE_CLOCK_COARSE_DELAY),
		.RST_VALUE(RST_SAMPLE_CLOCK_COARSE_DELAY)
	) u_coarse (
		.clk_in(clk_in),
		.rst_b_in(rst_n),
		.wr_bus(wr_bus),
		.word_out(coarse_word)
	);

	// =====================================================================
	// field outputs, straight from the word flip-flops
	// offset magnitude is a plain code; the analog side scales it at about 0.176 mV a step
	assign q_offset_mag_out = offset_word[OFS_MAG_MSB:OFS_MAG_LSB];
	assign q_offset_neg_out = offset_word[OFS_SIGN_BIT];
	// gain code passes straight to the trim; no calibration request exists here
	assign q_gain_code_out = gain_word[GAIN_MSB:GAIN_LSB];
	assign fine_delay_out = fine_word[FINE_MSB:FINE_LSB];
	assign clock_invert_select_out = coarse_word[POL_BIT];
	assign coarse_delay_out = coarse_word[COARSE_MSB:COARSE_LSB];
	assign intermediate_delay_out = coarse_word[INTER_MSB:INTER_LSB];

	// =====================================================================
	// combined delay, fixed-bit check and read answer
	logic [11:0] combined_reg;
	logic [11:0] combined_next;
	logic fixed_err_reg;
	logic fixed_err_next;
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	logic [15:0] ones_mask;
	logic mapped;

	// address decode picks the mask of bits that must be written as ones
	always_comb begin
		ones_mask = 16'h0000;
		mapped = 1'b0;
		if (wr_addr_in == ADDR_Q_OFFSET_TRIM) begin
			ones_mask = ONES_Q_OFFSET_TRIM;
			mapped = 1'b1;
		end else if (wr_addr_in == ADDR_Q_FULL_SCALE_TRIM) begin
			ones_mask = ONES_Q_FULL_SCALE_TRIM;
			mapped = 1'b1;
		end else if (wr_addr_in == ADDR_SAMPLE_CLOCK_FINE_DELAY) begin
			ones_mask = ONES_SAMPLE_CLOCK_FINE_DELAY;
			mapped = 1'b1;
		end else if (wr_addr_in == ADDR_SAMPLE_CLOCK_COARSE_DELAY) begin
			ones_mask = ONES_SAMPLE_CLOCK_COARSE_DELAY;
			mapped = 1'b1;
		end
	end

	// sum in picoseconds; 31 coarse and 7 intermediate steps reach 2092 ps
	always_comb begin
		combined_next = DELAY_SUM_W'(coarse_delay_out) * COARSE_STEP_PS
			+ DELAY_SUM_W'(intermediate_delay_out) * INTER_STEP_PS;
		fixed_err_next = wr_strobe_in && mapped && ((wr_data_in & ones_mask) != ones_mask);
		// the words are write-only, so a read answers zero rather than stale data
		rd_data_next = 16'h0000;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			combined_reg <= 12'h000;
			fixed_err_reg <= 1'b0;
			rd_data_reg <= 16'h0000;
		end else begin
			combined_reg <= combined_next;
			fixed_err_reg <= fixed_err_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign combined_delay_ps_out = combined_reg;
	assign fixed_bits_error_out = fixed_err_reg;
	assign rd_data_out = rd_data_reg;

	// =====================================================================
	// assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n);

	logic wr_ofs;
	logic wr_gain;
	logic wr_fine;
	logic wr_coarse;
	assign wr_ofs = wr_strobe_in && (wr_addr_in == ADDR_Q_OFFSET_TRIM);
	assign wr_gain = wr_strobe_in && (wr_addr_in == ADDR_Q_FULL_SCALE_TRIM);
	assign wr_fine = wr_strobe_in && (wr_addr_in == ADDR_SAMPLE_CLOCK_FINE_DELAY);
	assign wr_coarse = wr_strobe_in && (wr_addr_in == ADDR_SAMPLE_CLOCK_COARSE_DELAY);

	property p_offset_mag;
		wr_ofs |=> q_offset_mag_out == $past(wr_data_in[15:8]);
	endproperty
	a_offset_mag: assert property (p_offset_mag) else $error("offset magnitude not latched");

	property p_offset_sign;
		wr_ofs |=> q_offset_neg_out == $past(wr_data_in[7]);
	endproperty
	a_offset_sign: assert property (p_offset_sign) else $error("offset sign not latched");

	property p_offset_hold;
		!wr_ofs |=> $stable(q_offset_mag_out) && $stable(q_offset_neg_out);
	endproperty
	a_offset_hold: assert property (p_offset_hold) else $error("offset moved without write");

	property p_reset_values;
		$rose(rst_sync_reg[1]) |-> q_offset_mag_out == 8'h00 && !q_offset_neg_out
			&& q_gain_code_out == 9'h100 && fine_delay_out == 8'h00
			&& !clock_invert_select_out && coarse_delay_out == 5'h00
			&& intermediate_delay_out == 3'h0;
	endproperty
	a_reset_values: assert property (disable iff (!rst_b_in) p_reset_values)
		else $error("power-on field values wrong");

	property p_gain_latch;
		wr_gain |=> q_gain_code_out == $past(wr_data_in[15:7]);
	endproperty
	a_gain_latch: assert property (p_gain_latch) else $error("gain code not latched");

	property p_gain_hold;
		!wr_gain |=> $stable(q_gain_code_out);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

	property p_fine_latch;
		wr_fine |=> fine_delay_out == $past(wr_data_in[15:8]);
	endproperty
	a_fine_latch: assert property (p_fine_latch) else $error("fine delay not latched");

	property p_coarse_latch;
		wr_coarse |=> clock_invert_select_out == $past(wr_data_in[15])
			&& coarse_delay_out == $past(wr_data_in[14:10])
			&& intermediate_delay_out == $past(wr_data_in[9:7]);
	endproperty
	a_coarse_latch: assert property (p_coarse_latch) else $error("phase word not latched");

	property p_combined;
		wr_coarse |-> ##2 combined_delay_ps_out ==
			12'($past(wr_data_in[14:10], 2)) * 12'h041 + 12'($past(wr_data_in[9:7], 2)) * 12'h00b;
	endproperty
	a_combined: assert property (p_combined) else $error("combined delay sum wrong");

	property p_read_zero;
		rd_strobe_in |=> rd_data_out == 16'h0000;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("read returned data");

	property p_fixed_flag;
		wr_ofs && (wr_data_in[6:0] != 7'h7f) |=> fixed_bits_error_out;
	endproperty
	a_fixed_flag: assert property (p_fixed_flag) else $error("fixed bit slip not flagged");

	// every mapped word flags its own must-be-one slips, and nothing else raises the pulse
	property p_fixed_clean;
		wr_ofs && (wr_data_in[6:0] == 7'h7f) |=> !fixed_bits_error_out;
	endproperty
	a_fixed_clean: assert property (p_fixed_clean)
		else $error("clean offset write flagged");

	property p_fixed_gain;
		wr_gain && (wr_data_in[6:0] != 7'h7f) |=> fixed_bits_error_out;
	endproperty
	a_fixed_gain: assert property (p_fixed_gain)
		else $error("gain fixed bit slip not flagged");

	property p_fixed_fine;
		wr_fine && (wr_data_in[7:0] != 8'hff) |=> fixed_bits_error_out;
	endproperty
	a_fixed_fine: assert property (p_fixed_fine)
		else $error("fine fixed bit slip not flagged");

	property p_fixed_coarse;
		wr_coarse && (wr_data_in[6:0] != 7'h7f) |=> fixed_bits_error_out;
	endproperty
	a_fixed_coarse: assert property (p_fixed_coarse)
		else $error("phase fixed bit slip not flagged");

	property p_fixed_quiet;
		!(wr_ofs || wr_gain || wr_fine || wr_coarse) |=> !fixed_bits_error_out;
	endproperty
	a_fixed_quiet: assert property (p_fixed_quiet)
		else $error("error pulse without mapped write");

	// hold checks: a field moves only on a write to its own address
	property p_fine_hold;
		!wr_fine |=> $stable(fine_delay_out);
	endproperty
	a_fine_hold: assert property (p_fine_hold)
		else $error("fine delay moved without write");

	property p_phase_hold;
		!wr_coarse |=> $stable(clock_invert_select_out) && $stable(coarse_delay_out)
			&& $stable(intermediate_delay_out);
	endproperty
	a_phase_hold: assert property (p_phase_hold)
		else $error("phase moved without write");

	// the sum lags the phase word by one register, so it settles two edges after a write
	property p_combined_hold;
		!wr_coarse |-> ##2 $stable(combined_delay_ps_out);
	endproperty
	a_combined_hold: assert property (p_combined_hold)
		else $error("combined sum moved without write");

	c_offset_neg: cover property (wr_ofs && wr_data_in[7] ##1 q_offset_neg_out);
	c_gain_write: cover property (wr_gain ##1 wr_gain);
	c_invert: cover property (wr_coarse && wr_data_in[15] ##1 clock_invert_select_out);
	c_max_delay: cover property (combined_delay_ps_out == 12'h82c);

endmodule // adtp_trim_regs

// ===== verif/tb.sv
// self-checking bench for the second-channel trim and sample clock phase registers
// assumes the write/read port contract of the trim register top, one 100 MHz clock
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module tb;
	import adtp_pkg::*;
	// =====================================================================
	// clock, reset and design hookup
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [3:0] wr_addr_in = 4'h0;
	logic [15:0] wr_data_in = 16'h0000;
	logic wr_strobe_in = 1'b0;
	logic rd_strobe_in = 1'b0;
	logic [15:0] rd_data_out;
	logic [7:0] q_offset_mag_out;
	logic q_offset_neg_out;
	logic [8:0] q_gain_code_out;
	logic [7:0] fine_delay_out;
	logic clock_invert_select_out;
	logic [4:0] coarse_delay_out;
	logic [2:0] intermediate_delay_out;
	logic [11:0] combined_delay_ps_out;
	logic fixed_bits_error_out;
	int errors = 0;
	int n_compared = 0;
	int n_pulse = 0;

	adtp_trim_regs i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr_addr_in(wr_addr_in),
		.wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
		.rd_data_out(rd_data_out), .q_offset_mag_out(q_offset_mag_out),
		.q_offset_neg_out(q_offset_neg_out), .q_gain_code_out(q_gain_code_out),
		.fine_delay_out(fine_delay_out), .clock_invert_select_out(clock_invert_select_out),
		.coarse_delay_out(coarse_delay_out), .intermediate_delay_out(intermediate_delay_out),
		.combined_delay_ps_out(combined_delay_ps_out),
		.fixed_bits_error_out(fixed_bits_error_out));

	// free-running 10 ns clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	// counts error pulse cycles, so a stuck or doubled pulse shows as a wrong count
	always @(posedge clk_in) begin
		if (fixed_bits_error_out === 1'b1)
			n_pulse++;
	end

	// =====================================================================
	// bus tasks and checks
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_addr_in <= a;
		wr_data_in <= d;
		wr_strobe_in <= 1'b1;
		@(posedge clk_in);
		wr_strobe_in <= 1'b0;
	endtask

	// read data is zero in every cycle, so sampling it in the cycle after the strobe is enough
	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		wr_addr_in <= a;
		rd_strobe_in <= 1'b1;
		@(posedge clk_in);
		rd_strobe_in <= 1'b0;
		#1;
		`CHK(rd_data_out, 16'h0000)
	endtask

	// let the two-cycle combined delay land before looking
	task automatic chk(input logic [7:0] m, input logic n, input logic [8:0] g,
		input logic [7:0] f, input logic v, input logic [4:0] c, input logic [2:0] i);
		logic [11:0] e;
		e = 12'(c) * 12'h041 + 12'(i) * 12'h00b;
		repeat (3) @(posedge clk_in);
		#1;
		`CHK(q_offset_mag_out, m)
		`CHK(q_offset_neg_out, n)
		`CHK(q_gain_code_out, g)
		`CHK(fine_delay_out, f)
		`CHK(clock_invert_select_out, v)
		`CHK(coarse_delay_out, c)
		`CHK(intermediate_delay_out, i)
		`CHK(combined_delay_ps_out, e)
	endtask

	task automatic done(input string name);
		$display("test %s finished, %0d mismatches so far", name, errors);
	endtask

	task automatic stop_test;
		$display("compared %0d values, %0d mismatches", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// about 120 cycles of tests; 3000 cycles, some 25 times that, is a hang
	initial begin
		#30000;
		errors++;
		stop_test();
	end

	// =====================================================================
	// test sequence
	initial begin
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk(8'h00, 1'b0, 9'h100, 8'h00, 1'b0, 5'h00, 3'h0);
		rd(ADDR_Q_OFFSET_TRIM);
		done("reset");
		wr(4'ha, 16'ha5ff);
		chk(8'ha5, 1'b1, 9'h100, 8'h00, 1'b0, 5'h00, 3'h0);
		wr(4'ha, 16'hff7f);
		chk(8'hff, 1'b0, 9'h100, 8'h00, 1'b0, 5'h00, 3'h0);
		done("offset");
		wr(4'hb, 16'hffff);
		chk(8'hff, 1'b0, 9'h1ff, 8'h00, 1'b0, 5'h00, 3'h0);
		wr(4'hb, 16'h607f);
		chk(8'hff, 1'b0, 9'h0c0, 8'h00, 1'b0, 5'h00, 3'h0);
		done("gain");
		wr(4'he, 16'hffff);
		wr(4'hf, 16'hffff);
		chk(8'hff, 1'b0, 9'h0c0, 8'hff, 1'b1, 5'h1f, 3'h7);
		wr(4'hf, 16'h047f);
		chk(8'hff, 1'b0, 9'h0c0, 8'hff, 1'b0, 5'h01, 3'h0);
		wr(4'hf, 16'h00ff);
		chk(8'hff, 1'b0, 9'h0c0, 8'hff, 1'b0, 5'h00, 3'h1);
		done("phase");
		// unmapped writes, even with cleared must-be-one bits, change nothing
		for (int a = 0; a < 16; a++) begin
			if (!(a inside {10, 11, 14, 15}))
				wr(4'(a), 16'h0000);
		end
		chk(8'hff, 1'b0, 9'h0c0, 8'hff, 1'b0, 5'h00, 3'h1);
		rd(4'hf);
		rd(4'h3);
		`CHK(n_pulse, 0)
		done("unmapped");
		// cleared fixed bits are kept but flagged once per write
		wr(4'ha, 16'ha500);
		wr(4'he, 16'h12fe);
		wr(4'hb, 16'h6000);
		chk(8'ha5, 1'b0, 9'h0c0, 8'h12, 1'b0, 5'h00, 3'h1);
		`CHK(n_pulse, 3)
		done("fixed_bits");
		// back-to-back writes to three words with no idle cycle
		@(posedge clk_in);
		wr_strobe_in <= 1'b1;
		wr_addr_in <= 4'ha;
		wr_data_in <= 16'h01ff;
		@(posedge clk_in);
		wr_addr_in <= 4'hf;
		wr_data_in <= 16'h7c7f;
		@(posedge clk_in);
		wr_addr_in <= 4'hb;
		wr_data_in <= 16'h807f;
		@(posedge clk_in);
		wr_strobe_in <= 1'b0;
		chk(8'h01, 1'b1, 9'h100, 8'h12, 1'b0, 5'h1f, 3'h0);
		done("back_to_back");
		// reset in mid-run returns every field to its power-on value
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		chk(8'h00, 1'b0, 9'h100, 8'h00, 1'b0, 5'h00, 3'h0);
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		wr(4'hf, 16'h8000);
		chk(8'h00, 1'b0, 9'h100, 8'h00, 1'b1, 5'h00, 3'h0);
		done("reset_again");
		stop_test();
	end
endmodule // tb
